// ===== crm_cpu_regs.sv
`timescale 1ns/100ps
// Function
// - Eight banks, each of sixteen 8-bit general registers.
// - Two adjacent 8-bit registers read and write as one 16-bit pair.
// - Pairs four to seven join an expansion byte into 24-bit pointers.
// - Bank chosen by software write or by core context switch.
// - Banks live in RAM; four expansion bytes are separate flops.
// - Legacy alias names reach bank registers only while alias flag set.
// - Program counter is 20 bits and advances as instructions run.
// - Status high byte: user flag bit 15, bank field bits 14 to 12.
// - Status low byte holds flags, bit 1 always zero, updated by core.
// - Memory space is one megabyte, a 20-bit address.
// - Low option places data area below 10000H, ROM around it.
// - ROM under the low data window is not reachable as ROM.
// - High option places data area at the top of the space.
// - ROM under the low window is usable only with the high option.
// - Other addresses go external only in expansion mode.
module crm_cpu_regs #(
    parameter bit LARGE_PART = 1'b1
) (
    input  wire logic                             clk,
    input  wire logic                             rst_b,
    input  crm_pkg::crm_bus_t                     bus,
    output logic [crm_pkg::BUS_DATA_W-1:0]        rdata,
    input  crm_pkg::crm_core_t                    core,
    input  wire logic [crm_pkg::MEM_ADDR_W-1:0]   mem_addr,
    input  wire logic                             ext_mode,
    output crm_pkg::crm_region_t                  mem_region,
    output logic [crm_pkg::PC_W-1:0]              pc,
    output logic [crm_pkg::PSW_W-1:0]             program_status_word,
    output logic [crm_pkg::SP_W-1:0]              sp,
    output logic [crm_pkg::BANK_W-1:0]            active_bank,
    output logic                                  reloc_done,
    output logic                                  reloc_high
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [crm_pkg::GPR_W-1:0]     gpr_ram [crm_pkg::NUM_BANKS *
                                            crm_pkg::REGS_PER_BANK];
    logic [crm_pkg::GPR_W-1:0]     exp_reg [crm_pkg::NUM_EXP];
    logic                          g_byte;
    logic                          g_pair;
    logic [crm_pkg::REG_IDX_W-1:0] g_idx;
    logic [crm_pkg::RAM_IDX_W-1:0] lo_addr;
    logic [crm_pkg::RAM_IDX_W-1:0] hi_addr;
    logic                          in_ptr;
    logic                          in_exp;
    logic [1:0]                    exp_sel;
    logic [crm_pkg::PSW_W-1:0]     next_psw;
    logic [crm_pkg::BUS_DATA_W-1:0] next_rdata;
    crm_pkg::crm_reloc_t           reloc_state;
    crm_pkg::crm_region_t          next_region;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign active_bank = program_status_word[crm_pkg::PSW_RBS_HI:crm_pkg::PSW_RBS_LO];
    assign in_ptr  = bus.addr >= crm_pkg::OFS_PTR &&
                     bus.addr <  crm_pkg::OFS_EXP;
    assign in_exp  = bus.addr >= crm_pkg::OFS_EXP &&
                     bus.addr <  crm_pkg::OFS_PSW;
    assign exp_sel = bus.addr[1:0];

    always_comb begin
        g_byte = 1'b0;
        g_pair = 1'b0;
        g_idx  = '0;
        if (bus.addr < crm_pkg::OFS_PAIR) begin
            g_byte = 1'b1;
            g_idx  = bus.addr[3:0];
        end else if (bus.addr < crm_pkg::OFS_PTR) begin
            g_pair = 1'b1;
            g_idx  = {bus.addr[2:0], 1'b0};
        end else if (in_ptr) begin
            g_pair = 1'b1;
            g_idx  = {1'b1, bus.addr[1:0], 1'b0};
        end else if (program_status_word[crm_pkg::PSW_RSS] &&
                     bus.addr >= crm_pkg::OFS_ALIAS_B &&
                     bus.addr <  crm_pkg::OFS_ALIAS_P) begin
            g_byte = 1'b1;
            g_idx  = {2'b01, bus.addr[1:0]};
        end else if (program_status_word[crm_pkg::PSW_RSS] &&
                     bus.addr >= crm_pkg::OFS_ALIAS_P &&
                     bus.addr <  crm_pkg::OFS_ALIAS_E) begin
            g_pair = 1'b1;
            g_idx  = {2'b01, bus.addr[0], 1'b0};
        end
    end

    assign lo_addr = {active_bank, g_idx};
    assign hi_addr = {active_bank, g_idx | 4'h1};

    // ------------------------------------------------------------------
    // General register RAM
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (bus.wr && (g_byte || g_pair)) begin
            gpr_ram[lo_addr] <= bus.wdata[7:0];
        end
        if (bus.wr && g_pair) begin
            gpr_ram[hi_addr] <= bus.wdata[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Address expansion registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < crm_pkg::NUM_EXP; i++) begin
                exp_reg[i] <= 8'h00;
            end
        end else if (bus.wr && in_ptr) begin
            exp_reg[exp_sel] <= bus.wdata[23:16];
        end else if (bus.wr && in_exp) begin
            exp_reg[exp_sel] <= bus.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_comb begin
        next_psw = program_status_word;
        if (core.flag_we) begin
            next_psw[7:0] = core.flags & crm_pkg::FLAG_MASK;
        end
        if (bus.wr && bus.addr == crm_pkg::OFS_PSW) begin
            next_psw = bus.wdata[15:0] & crm_pkg::PSW_WMASK;
        end
        if (core.ctx_sw) begin
            next_psw[crm_pkg::PSW_RBS_HI:crm_pkg::PSW_RBS_LO] =
                core.ctx_bank;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            program_status_word <= crm_pkg::PSW_RESET;
        end else begin
            program_status_word <= next_psw;
        end
    end

    // ------------------------------------------------------------------
    // Program counter and stack pointer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc <= crm_pkg::PC_RESET;
        end else if (bus.wr && bus.addr == crm_pkg::OFS_PC) begin
            pc <= bus.wdata[19:0];
        end else if (core.pc_adv) begin
            pc <= pc + {17'h00000, core.pc_step};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sp <= crm_pkg::SP_RESET;
        end else if (bus.wr && bus.addr == crm_pkg::OFS_SP) begin
            sp <= bus.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Data area relocation
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reloc_state <= crm_pkg::RL_UNSET;
            reloc_done  <= 1'b0;
            reloc_high  <= 1'b0;
        end else begin
            case (reloc_state)
                crm_pkg::RL_UNSET: begin
                    if (bus.wr && bus.addr == crm_pkg::OFS_RELOCATE) begin
                        if (bus.wdata[7:0] == crm_pkg::RELOC_LOW_OP) begin
                            reloc_state <= crm_pkg::RL_LOW;
                            reloc_done  <= 1'b1;
                        end else if (bus.wdata[7:0] ==
                                     crm_pkg::RELOC_HIGH_OP) begin
                            reloc_state <= crm_pkg::RL_HIGH;
                            reloc_done  <= 1'b1;
                            reloc_high  <= 1'b1;
                        end
                    end
                end
                crm_pkg::RL_LOW: begin
                    reloc_state <= crm_pkg::RL_LOW;
                end
                crm_pkg::RL_HIGH: begin
                    reloc_state <= crm_pkg::RL_HIGH;
                end
                default: begin
                    reloc_state <= crm_pkg::RL_UNSET;
                    reloc_done  <= 1'b0;
                    reloc_high  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Memory map decode
    // ------------------------------------------------------------------
    crm_map_decode #(
        .LARGE_PART (LARGE_PART)
    ) u_decode (
        .addr     (mem_addr),
        .high     (reloc_high),
        .ext_mode (ext_mode),
        .region   (next_region)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_region <= crm_pkg::RG_NONE;
        end else begin
            mem_region <= next_region;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (g_byte) begin
            next_rdata = {16'h0000, gpr_ram[lo_addr]};
        end else if (g_pair) begin
            next_rdata = {8'h00, gpr_ram[hi_addr], gpr_ram[lo_addr]};
            if (in_ptr) begin
                next_rdata[23:16] = exp_reg[exp_sel];
            end
        end else if (in_exp) begin
            next_rdata = {16'h0000, exp_reg[exp_sel]};
        end else if (bus.addr == crm_pkg::OFS_PSW) begin
            next_rdata = {8'h00, program_status_word};
        end else if (bus.addr == crm_pkg::OFS_PC) begin
            next_rdata = {4'h0, pc};
        end else if (bus.addr == crm_pkg::OFS_SP) begin
            next_rdata = sp;
        end else if (bus.addr == crm_pkg::OFS_MAP_STAT) begin
            next_rdata = {22'h000000, reloc_high, reloc_done};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_pc_advance: assert property (
        core.pc_adv && !(bus.wr && bus.addr == crm_pkg::OFS_PC)
        |=> pc == $past(pc) + {17'h00000, $past(core.pc_step)})
        else $error("pc did not advance by step");

    a_psw_fixed_bits: assert property (
        program_status_word[1] == 1'b0 && program_status_word[11:8] == 4'h0)
        else $error("psw fixed bits not zero");

    a_ctx_bank: assert property (
        core.ctx_sw |=> active_bank == $past(core.ctx_bank))
        else $error("context switch bank not taken");

    a_bank_write: assert property (
        bus.wr && bus.addr == crm_pkg::OFS_PSW && !core.ctx_sw
        |=> active_bank == $past(bus.wdata[14:12]) &&
            program_status_word[15] == $past(bus.wdata[15]))
        else $error("status word write lost");

    a_reloc_once: assert property (
        reloc_done |=> reloc_done && $stable(reloc_high))
        else $error("relocation changed twice");

    a_alias_gate: assert property (
        bus.rd && bus.addr == crm_pkg::OFS_ALIAS_B &&
        !program_status_word[crm_pkg::PSW_RSS] |=> rdata == '0)
        else $error("alias readable with flag clear");

    a_pair_roundtrip: assert property (
        bus.wr && bus.addr == crm_pkg::OFS_PAIR && !core.ctx_sw
        ##1 bus.rd && bus.addr == crm_pkg::OFS_PAIR && !core.ctx_sw &&
        !$past(core.ctx_sw)
        |=> rdata[15:0] == $past(bus.wdata[15:0], 2))
        else $error("pair readback mismatch");

    a_high_data: assert property (
        reloc_high && mem_addr >= (crm_pkg::DATA_BASE_SML |
        crm_pkg::HIGH_OFFSET) |=> mem_region == crm_pkg::RG_DATA)
        else $error("high data window not decoded");

    a_low_hole: assert property (
        !reloc_high && mem_addr >= crm_pkg::DATA_BASE_SML &&
        mem_addr <= crm_pkg::DATA_TOP_LOW
        |=> mem_region == crm_pkg::RG_DATA)
        else $error("low window decoded as rom");

    a_ext_gate: assert property (
        !ext_mode |=> mem_region != crm_pkg::RG_EXT)
        else $error("external region without expansion mode");

    c_reloc_high: cover property (
        bus.wr && bus.addr == crm_pkg::OFS_RELOCATE ##1 reloc_high);
    c_ptr_read: cover property (bus.rd && in_ptr);
    c_ctx_switch: cover property (core.ctx_sw ##1 bus.rd && g_byte);
    c_ext_access: cover property (mem_region == crm_pkg::RG_EXT);

endmodule : crm_cpu_regs

// ===== crm_map_decode.sv
`timescale 1ns/100ps
module crm_map_decode #(
    parameter bit LARGE_PART = 1'b1
) (
    input  wire logic [crm_pkg::MEM_ADDR_W-1:0] addr,
    input  wire logic                            high,
    input  wire logic                            ext_mode,
    output crm_pkg::crm_region_t                 region
);

    logic [crm_pkg::MEM_ADDR_W-1:0] data_base;
    logic [crm_pkg::MEM_ADDR_W-1:0] rom_top;
    logic                            in_data;
    logic                            in_rom;

    assign data_base = LARGE_PART ? crm_pkg::DATA_BASE_BIG
                                  : crm_pkg::DATA_BASE_SML;
    assign rom_top   = LARGE_PART ? crm_pkg::ROM_TOP_BIG
                                  : crm_pkg::ROM_TOP_SML;

    // ------------------------------------------------------------------
    // Window placement
    // ------------------------------------------------------------------
    always_comb begin
        if (high) begin
            in_data = addr >= (data_base | crm_pkg::HIGH_OFFSET);
        end else begin
            in_data = addr >= data_base &&
                      addr <= crm_pkg::DATA_TOP_LOW;
        end
        in_rom = addr <= rom_top && !in_data;
    end

    always_comb begin
        if (in_data) begin
            region = crm_pkg::RG_DATA;
        end else if (in_rom) begin
            region = crm_pkg::RG_ROM;
        end else if (ext_mode) begin
            region = crm_pkg::RG_EXT;
        end else begin
            region = crm_pkg::RG_NONE;
        end
    end

endmodule : crm_map_decode

// ===== crm_pkg.sv
package crm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_BANKS     = 8;
    localparam int REGS_PER_BANK = 16;
    localparam int BANK_W        = 3;
    localparam int REG_IDX_W     = 4;
    localparam int RAM_IDX_W     = BANK_W + REG_IDX_W;
    localparam int GPR_W         = 8;
    localparam int PAIR_W        = 16;
    localparam int PTR_W         = 24;
    localparam int NUM_EXP       = 4;
    localparam int MEM_ADDR_W    = 20;
    localparam int PC_W          = 20;
    localparam int SP_W          = 24;
    localparam int PSW_W         = 16;
    localparam int BUS_ADDR_W    = 8;
    localparam int BUS_DATA_W    = 24;
    localparam int STEP_W        = 3;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_GPR      = 8'h00;
    localparam logic [7:0] OFS_PAIR     = 8'h10;
    localparam logic [7:0] OFS_PTR      = 8'h18;
    localparam logic [7:0] OFS_EXP      = 8'h1c;
    localparam logic [7:0] OFS_PSW      = 8'h20;
    localparam logic [7:0] OFS_PC       = 8'h21;
    localparam logic [7:0] OFS_SP       = 8'h22;
    localparam logic [7:0] OFS_RELOCATE = 8'h23;
    localparam logic [7:0] OFS_MAP_STAT = 8'h24;
    localparam logic [7:0] OFS_ALIAS_B  = 8'h28;
    localparam logic [7:0] OFS_ALIAS_P  = 8'h2c;
    localparam logic [7:0] OFS_ALIAS_E  = 8'h2e;

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int PSW_UF     = 15;
    localparam int PSW_RBS_HI = 14;
    localparam int PSW_RBS_LO = 12;
    localparam int PSW_RSS    = 5;
    localparam logic [15:0] PSW_WMASK = 16'hf0fd;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [7:0]  FLAG_MASK = 8'hfd;

    localparam logic [19:0] PC_RESET  = 20'h00000;
    localparam logic [23:0] SP_RESET  = 24'h000000;

    // ------------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------------
    localparam logic [7:0]  RELOC_LOW_OP  = 8'h00;
    localparam logic [7:0]  RELOC_HIGH_OP = 8'h0f;
    localparam logic [19:0] DATA_BASE_BIG = 20'h0f100;
    localparam logic [19:0] DATA_BASE_SML = 20'h0f700;
    localparam logic [19:0] DATA_TOP_LOW  = 20'h0ffff;
    localparam logic [19:0] HIGH_OFFSET   = 20'hf0000;
    localparam logic [19:0] ROM_TOP_BIG   = 20'h1ffff;
    localparam logic [19:0] ROM_TOP_SML   = 20'h17fff;

    typedef enum logic [3:0] {
        RG_NONE = 4'h1,
        RG_ROM  = 4'h2,
        RG_DATA = 4'h4,
        RG_EXT  = 4'h8
    } crm_region_t;

    typedef enum logic [2:0] {
        RL_UNSET = 3'h1,
        RL_LOW   = 3'h2,
        RL_HIGH  = 3'h4
    } crm_reloc_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [BUS_ADDR_W-1:0] addr;
        logic [BUS_DATA_W-1:0] wdata;
    } crm_bus_t;

    typedef struct packed {
        logic              pc_adv;
        logic [STEP_W-1:0] pc_step;
        logic              flag_we;
        logic [7:0]        flags;
        logic              ctx_sw;
        logic [BANK_W-1:0] ctx_bank;
    } crm_core_t;

endpackage : crm_pkg

// ===== test_cpu_registers_memory_map.sv
`timescale 1ns/100ps
module test_cpu_registers_memory_map;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                 clk          = 1'b0;
    logic                 rst_b        = 1'b0;
    crm_pkg::crm_bus_t    bus          = '0;
    crm_pkg::crm_core_t   core         = '0;
    logic [19:0]          mem_addr     = '0;
    logic                 ext_mode     = 1'b0;
    logic [23:0]          rdata;
    crm_pkg::crm_region_t mem_region;
    crm_pkg::crm_region_t mem_region_sml;
    logic [19:0]          pc;
    logic [15:0]          program_status_word;
    logic [23:0]          sp;
    logic [2:0]           active_bank;
    logic                 reloc_done;
    logic                 reloc_high;
    int                   fail_count   = 0;
    int                   total_checks = 0;
    logic [7:0]           gpr [8][16];
    logic [23:0]          v;
    logic [19:0]          corner [16] = '{20'h00000, 20'h0f0ff, 20'h0f100,
        20'h0f6ff, 20'h0f700, 20'h0ffff, 20'h10000, 20'h17fff, 20'h18000,
        20'h1ffff, 20'h20000, 20'hff0ff, 20'hff100, 20'hff6ff, 20'hff700,
        20'hfffff};

    always #10 clk = ~clk;

    crm_cpu_regs #(.LARGE_PART(1'b1)) dut (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .core(core),
        .mem_addr(mem_addr), .ext_mode(ext_mode), .mem_region(mem_region),
        .pc(pc), .program_status_word(program_status_word), .sp(sp), .active_bank(active_bank),
        .reloc_done(reloc_done), .reloc_high(reloc_high));

    crm_cpu_regs #(.LARGE_PART(1'b0)) dut_sml (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(), .core(core),
        .mem_addr(mem_addr), .ext_mode(ext_mode),
        .mem_region(mem_region_sml), .pc(), .program_status_word(), .sp(),
        .active_bank(), .reloc_done(), .reloc_high());

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] exp_region(logic [19:0] a, logic hi,
                                              logic ex, logic big);
        logic [19:0] base;
        logic [19:0] top;
        base = big ? 20'h0f100 : 20'h0f700;
        top  = big ? 20'h1ffff : 20'h17fff;
        if (hi) base = base | 20'hf0000;
        if (a >= base && a <= (base | 20'h00fff)) return 4'h4;
        if (a <= top) return 4'h2;
        return ex ? 4'h8 : 4'h1;
    endfunction : exp_region

    task automatic check(input string n, input logic [23:0] e,
                         input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : check

    // The write strobe stays high; the next read or an idle lowers it.
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        bus.wr   <= 1'b0;
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd   <= 1'b0;
        @(negedge clk);
        check($sformatf("reg %h", a), e, rdata);
        @(posedge clk);
    endtask : rd

    task automatic map(input logic [19:0] a, input logic ex, input logic hi);
        mem_addr <= a;
        ext_mode <= ex;
        @(posedge clk);
        @(negedge clk);
        check("mem_region", {20'h0, exp_region(a, hi, ex, 1'b1)},
              {20'h0, mem_region});
        check("mem_region_sml", {20'h0, exp_region(a, hi, ex, 1'b0)},
              {20'h0, mem_region_sml});
        @(posedge clk);
    endtask : map

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #(20 * 30000);
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(61064));
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("reset pc", 24'h0, {4'h0, pc});
        check("reset psw", 24'h0, {8'h0, program_status_word});
        check("reset sp", 24'h0, sp);
        check("reset rdata", 24'h0, rdata);
        check("reset reloc", 24'h0, {22'h0, reloc_high, reloc_done});
        check("reset region", 24'h1, {20'h0, mem_region});
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        $display("test reset done");
        for (int b = 0; b < 8; b++) begin
            wr(8'h20, 24'(b << 12));
            for (int r = 0; r < 16; r++) begin
                gpr[b][r] = 8'($urandom);
                wr(8'(r), {16'h0, gpr[b][r]});
            end
        end
        for (int b = 7; b >= 0; b--) begin
            wr(8'h20, 24'(b << 12));
            rd(8'h20, 24'(b << 12));
            check("active_bank", 24'(b), {21'h0, active_bank});
            for (int r = 0; r < 16; r++) rd(8'(r), {16'h0, gpr[b][r]});
        end
        $display("test banks done");
        for (int k = 0; k < 8; k++) begin
            v = {8'h0, 16'($urandom)};
            wr(8'h10 + 8'(k), v);
            rd(8'h10 + 8'(k), v);
            rd(8'(2 * k), {16'h0, v[7:0]});
            rd(8'(2 * k + 1), {16'h0, v[15:8]});
        end
        for (int k = 0; k < 4; k++) begin
            v = 24'($urandom);
            wr(8'h18 + 8'(k), v);
            wr(8'h20, 24'h001000);
            rd(8'h1c + 8'(k), {16'h0, v[23:16]});
            rd(8'h18 + 8'(k),
               {v[23:16], gpr[1][2 * k + 9], gpr[1][2 * k + 8]});
            wr(8'h20, 24'h000000);
            rd(8'h18 + 8'(k), v);
        end
        $display("test pairs done");
        wr(8'h04, 24'h00005a);
        rd(8'h28, 24'h0);
        wr(8'h20, 24'h000020);
        rd(8'h28, 24'h00005a);
        wr(8'h12, 24'h00c3a5);
        rd(8'h2c, 24'h00c3a5);
        wr(8'h20, 24'h00ffff);
        rd(8'h20, 24'h00f0fd);
        core.flag_we <= 1'b1;
        core.flags   <= 8'hff;
        core.ctx_sw  <= 1'b1;
        core.ctx_bank <= 3'h5;
        @(posedge clk);
        core <= '0;
        @(negedge clk);
        check("psw", 24'h00d0fd, {8'h0, program_status_word});
        check("active_bank", 24'h5, {21'h0, active_bank});
        @(posedge clk);
        wr(8'h20, 24'h000000);
        rd(8'h20, 24'h000000);
        wr(8'h21, 24'h0ffffe);
        bus.wr       <= 1'b0;
        core.pc_adv  <= 1'b1;
        core.pc_step <= 3'h3;
        repeat (2) @(posedge clk);
        core <= '0;
        @(negedge clk);
        check("pc", 24'h000004, {4'h0, pc});
        @(posedge clk);
        wr(8'h22, 24'h0abcde);
        rd(8'h22, 24'h0abcde);
        $display("test status done");
        for (int i = 0; i < 16; i++) map(corner[i], i[0], 1'b0);
        map(20'h0f200, 1'b0, 1'b0);
        for (int i = 0; i < 20; i++) map(20'($urandom), 1'b1, 1'b0);
        wr(8'h23, 24'h000005);
        rd(8'h24, 24'h0);
        wr(8'h23, 24'h00000f);
        wr(8'h23, 24'h000000);
        rd(8'h24, 24'h3);
        check("reloc_high", 24'h1, {23'h0, reloc_high});
        for (int i = 0; i < 16; i++) map(corner[i], i[1], 1'b1);
        map(20'h0f800, 1'b0, 1'b1);
        for (int i = 0; i < 20; i++) map(20'($urandom), 1'b0, 1'b1);
        $display("test map done");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check("reloc", 24'h0, {22'h0, reloc_high, reloc_done});
        @(posedge clk);
        wr(8'h23, 24'h000000);
        rd(8'h24, 24'h1);
        map(20'h0f800, 1'b0, 1'b0);
        $display("test second reset done");
        conclude();
    end

endmodule : test_cpu_registers_memory_map
